// ==== uoc_pkg.sv ====
// Package of register offsets, field positions, reset values and timing for the USB control block.
package uoc_pkg;
  localparam logic [7:0] UOC_OFF_CONTROL = 8'h00;
  localparam logic [7:0] UOC_OFF_ADDRESS = 8'h04;
  localparam logic [7:0] UOC_OFF_FRAME_LOW = 8'h08;
  localparam logic [7:0] UOC_OFF_FRAME_HIGH = 8'h0C;
  localparam int UOC_BIT_IDLE_DIFF = 7;
  localparam int UOC_BIT_SE0 = 6;
  localparam int UOC_BIT_HOLD_BUSY = 5;
  localparam int UOC_BIT_BUS_RESET = 4;
  localparam int UOC_BIT_HOST_EN = 3;
  localparam int UOC_BIT_RESUME = 2;
  localparam int UOC_BIT_PP_CLEAR = 1;
  localparam int UOC_BIT_EN_SOF = 0;
  localparam int UOC_BIT_LOW_SPEED = 7;
  localparam logic [7:0] UOC_CONTROL_RST = 8'h00;
  localparam logic [7:0] UOC_ADDRESS_RST = 8'h00;
  localparam logic [10:0] UOC_FRAME_RST = 11'h000;
  localparam int UOC_CLK_MHZ = 125;
  localparam int UOC_FRAME_US = 1000;
  localparam int UOC_FRAME_CYCLES = UOC_FRAME_US * UOC_CLK_MHZ;
  localparam int UOC_LS_EOP_NS = 1334;
  localparam int UOC_LS_EOP_CYCLES = (UOC_LS_EOP_NS * UOC_CLK_MHZ + 999) / 1000;
  localparam int UOC_HOST_RST_CYCLES = 2;
  typedef enum logic [3:0] {
    UOC_RS_IDLE = 4'h1,
    UOC_RS_DRIVE = 4'h2,
    UOC_RS_EOP = 4'h4,
    UOC_RS_DONE = 4'h8
  } uoc_resume_t;
endpackage

// ==== uoc_frame_timer.sv ====
// Free-running frame interval timer that pulses once per frame period.
`timescale 1ns/1ps
`default_nettype none
module uoc_frame_timer import uoc_pkg::*; #(
  parameter int FRAME_CYCLES = UOC_FRAME_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic run,
  // Tick
  output logic tick
);
  logic [23:0] count_r;

  always_ff @(posedge clk) begin
    if (srst || !run) begin
      count_r <= 24'h000000;
      tick <= 1'b0;
    end else if (count_r == 24'(FRAME_CYCLES - 1)) begin
      count_r <= 24'h000000;
      tick <= 1'b1;
    end else begin
      count_r <= count_r + 24'h000001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== uoc_control.sv ====
// Control, address and frame-number registers of the full-speed USB OTG link logic.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module uoc_control import uoc_pkg::*; #(
  parameter int FRAME_CYCLES = UOC_FRAME_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Line receiver
  input wire logic line_j_state,
  input wire logic line_se0,
  // Protocol engine events
  input wire logic setup_token_rx,
  input wire logic sof_token_rx,
  input wire logic [10:0] sof_frame_number,
  input wire logic token_start,
  input wire logic token_done,
  // Controls to the link
  output logic module_enable,
  output logic host_mode,
  output logic host_logic_reset,
  output logic bus_reset_drive,
  output logic resume_drive,
  output logic resume_ls_eop,
  output logic pingpong_pointer_clear,
  output logic packet_processing_hold,
  output logic sof_send,
  output logic low_speed_next_token,
  output logic [6:0] device_address_field
);
  // Stored register state; bit 5 of control is computed on read, not stored.
  logic [7:0] ctrl_r;
  logic [7:0] addr_r;
  logic [10:0] frame_r;
  logic hold_r;
  logic busy_r;
  logic host_prev_r;
  logic [1:0] host_rst_cnt_r;
  logic [7:0] eop_cnt_r;
  logic frame_tick;
  uoc_resume_t rs_r;

  // Address match, shared by the write decode, the read mux and the checks.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire host_en = ctrl_r[UOC_BIT_HOST_EN];
  wire ctrl_wr = reg_wr && hit(reg_addr, UOC_OFF_CONTROL);
  wire host_toggle = host_en != host_prev_r;

  // Control bits; bit 5 is not stored here since it is hold or busy.
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= UOC_CONTROL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= {3'h0, reg_wdata[4:0]};
    end
  end

  // Address register: bit 7 picks the speed of the next token, the rest is the address.
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_r <= UOC_ADDRESS_RST;
    end else if (reg_wr && hit(reg_addr, UOC_OFF_ADDRESS)) begin
      addr_r <= reg_wdata[7:0];
    end
  end

  // Hold is set by SETUP in device mode; the set wins over a software clear.
  // Entering host mode drops the hold, since bit 5 then reports token busy instead.
  always_ff @(posedge clk) begin
    if (srst || host_en) begin
      hold_r <= 1'b0;
    end else if (setup_token_rx) begin
      hold_r <= 1'b1;
    end else if (ctrl_wr && !reg_wdata[UOC_BIT_HOLD_BUSY]) begin
      hold_r <= 1'b0;
    end
  end

  // Token busy lives in host logic, so a host-enable toggle clears it.
  always_ff @(posedge clk) begin
    if (srst || !host_en || host_toggle) begin
      busy_r <= 1'b0;
    end else if (token_start) begin
      busy_r <= 1'b1;
    end else if (token_done) begin
      busy_r <= 1'b0;
    end
  end

  // Both frame registers load from one word, so high and low never mix two frames.
  always_ff @(posedge clk) begin
    if (srst) begin
      frame_r <= UOC_FRAME_RST;
    end else if (sof_token_rx) begin
      frame_r <= sof_frame_number;
    end
  end

  // Host reset pulse stretched a little so host logic sees it for sure.
  always_ff @(posedge clk) begin
    if (srst) begin
      host_prev_r <= 1'b0;
      host_rst_cnt_r <= 2'h0;
    end else begin
      host_prev_r <= host_en;
      if (host_toggle) begin
        host_rst_cnt_r <= 2'(UOC_HOST_RST_CYCLES);
      end else if (host_rst_cnt_r != 2'h0) begin
        host_rst_cnt_r <= host_rst_cnt_r - 2'h1;
      end
    end
  end

  // Resume sequencer: host mode ends with a low-speed end-of-packet.
  // In device mode clearing the bit simply stops the signalling; no end-of-packet follows.
  always_ff @(posedge clk) begin
    if (srst) begin
      rs_r <= UOC_RS_IDLE;
      eop_cnt_r <= 8'h00;
    end else begin
      case (rs_r)
        UOC_RS_IDLE: begin
          if (ctrl_r[UOC_BIT_RESUME]) begin
            rs_r <= UOC_RS_DRIVE;
          end
        end
        UOC_RS_DRIVE: begin
          if (!ctrl_r[UOC_BIT_RESUME]) begin
            if (host_en) begin
              rs_r <= UOC_RS_EOP;
              eop_cnt_r <= 8'(UOC_LS_EOP_CYCLES);
            end else begin
              rs_r <= UOC_RS_IDLE;
            end
          end
        end
        UOC_RS_EOP: begin
          if (eop_cnt_r == 8'h01) begin
            rs_r <= UOC_RS_DONE;
          end
          eop_cnt_r <= eop_cnt_r - 8'h01;
        end
        UOC_RS_DONE: begin
          rs_r <= UOC_RS_IDLE;
        end
        default: begin
          rs_r <= UOC_RS_IDLE;
        end
      endcase
    end
  end

  // The frame timer waits out the host reset so the first frame starts from a clean count.
  uoc_frame_timer #(
    .FRAME_CYCLES(FRAME_CYCLES)
  ) u_frame_timer (
    .clk(clk),
    .srst(srst),
    .run(host_en && ctrl_r[UOC_BIT_EN_SOF] && host_rst_cnt_r == 2'h0),
    .tick(frame_tick)
  );

  // All link controls are registered so they come straight from flops.
  // The cost is one cycle of latency between a register write and the pins.
  always_ff @(posedge clk) begin
    if (srst) begin
      module_enable <= 1'b0;
      host_mode <= 1'b0;
      host_logic_reset <= 1'b0;
      bus_reset_drive <= 1'b0;
      resume_drive <= 1'b0;
      resume_ls_eop <= 1'b0;
      pingpong_pointer_clear <= 1'b0;
      packet_processing_hold <= 1'b0;
      sof_send <= 1'b0;
      low_speed_next_token <= 1'b0;
      device_address_field <= 7'h00;
    end else begin
      module_enable <= !host_en && ctrl_r[UOC_BIT_EN_SOF];
      host_mode <= host_en;
      host_logic_reset <= host_toggle || host_rst_cnt_r != 2'h0;
      bus_reset_drive <= host_en && ctrl_r[UOC_BIT_BUS_RESET];
      resume_drive <= ctrl_r[UOC_BIT_RESUME];
      resume_ls_eop <= rs_r == UOC_RS_EOP;
      pingpong_pointer_clear <= ctrl_r[UOC_BIT_PP_CLEAR];
      packet_processing_hold <= hold_r;
      sof_send <= frame_tick;
      low_speed_next_token <= addr_r[UOC_BIT_LOW_SPEED];
      device_address_field <= addr_r[6:0];
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads zero.
  // Reads have no side effects, so software may poll bit 5 as often as it likes.
  always_ff @(posedge clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else if (hit(reg_addr, UOC_OFF_CONTROL)) begin
      reg_rdata <= {24'h000000, line_j_state, line_se0,
                    host_en ? busy_r : hold_r, ctrl_r[4:0]};
    end else if (hit(reg_addr, UOC_OFF_ADDRESS)) begin
      reg_rdata <= {24'h000000, addr_r};
    end else if (hit(reg_addr, UOC_OFF_FRAME_LOW)) begin
      reg_rdata <= {24'h000000, frame_r[7:0]};
    end else if (hit(reg_addr, UOC_OFF_FRAME_HIGH)) begin
      reg_rdata <= {29'h00000000, frame_r[10:8]};
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  chk_hold_setup: assert property (@(posedge clk) disable iff (srst)
    (!host_en && setup_token_rx && !host_prev_r) |=> ##1 packet_processing_hold)
    else $error("hold not set after setup token");
  chk_busy_token: assert property (@(posedge clk) disable iff (srst)
    (host_en && !host_toggle && token_start) |=> busy_r)
    else $error("token busy not set");
  chk_bus_reset: assert property (@(posedge clk) disable iff (srst)
    bus_reset_drive |-> $past(host_en && ctrl_r[UOC_BIT_BUS_RESET]))
    else $error("bus reset driven without cause");
  chk_host_reset: assert property (@(posedge clk) disable iff (srst)
    host_toggle |=> host_logic_reset [*3])
    else $error("host logic not reset on toggle");
  chk_resume_eop: assert property (@(posedge clk) disable iff (srst)
    (rs_r == UOC_RS_DRIVE && !ctrl_r[UOC_BIT_RESUME] && host_en) |=> ##1 resume_ls_eop)
    else $error("no low-speed eop after resume");
  chk_frame_load: assert property (@(posedge clk) disable iff (srst)
    sof_token_rx |=> frame_r == $past(sof_frame_number))
    else $error("frame number not captured");
  chk_read_high: assert property (@(posedge clk) disable iff (srst)
    (reg_rd && hit(reg_addr, UOC_OFF_FRAME_HIGH)) |=> reg_rdata[31:3] == 29'h00000000)
    else $error("frame high upper bits not zero");
  chk_addr_ctrl: assert property (@(posedge clk) disable iff (srst)
    (reg_rd && hit(reg_addr, UOC_OFF_CONTROL)) |=> reg_rdata[31:8] == 24'h000000)
    else $error("control upper bits not zero");
  chk_sof_mode: assert property (@(posedge clk) disable iff (srst)
    sof_send |-> $past(host_en, 2))
    else $error("frame start outside host mode");

  // Line flags and read-back framing.
  chk_line_idle: assert property (@(posedge clk) disable iff (srst)
    (reg_rd && hit(reg_addr, UOC_OFF_CONTROL)) |=> reg_rdata[UOC_BIT_IDLE_DIFF] == $past(line_j_state))
    else $error("idle line flag does not follow the receiver");
  chk_line_se0: assert property (@(posedge clk) disable iff (srst)
    (reg_rd && hit(reg_addr, UOC_OFF_CONTROL)) |=> reg_rdata[UOC_BIT_SE0] == $past(line_se0))
    else $error("single-ended zero flag does not follow the lines");
  chk_read_idle: assert property (@(posedge clk) disable iff (srst)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero outside a read");
  chk_ctrl_upper: assert property (@(posedge clk) disable iff (srst)
    ctrl_r[7:5] == 3'h0)
    else $error("unimplemented control bits stored");
  chk_high_bits: assert property (@(posedge clk) disable iff (srst)
    (reg_rd && hit(reg_addr, UOC_OFF_FRAME_HIGH)) |=> reg_rdata[2:0] == $past(frame_r[10:8]))
    else $error("frame high bits wrong");

  // Address register.
  chk_addr_load: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && hit(reg_addr, UOC_OFF_ADDRESS)) |=>
      ##1 device_address_field == $past(reg_wdata[6:0], 2))
    else $error("device address not loaded");
  chk_low_speed: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && hit(reg_addr, UOC_OFF_ADDRESS)) |=>
      ##1 low_speed_next_token == $past(reg_wdata[UOC_BIT_LOW_SPEED], 2))
    else $error("low-speed selector not loaded");

  // Link controls in host and device mode.
  chk_busy_clear: assert property (@(posedge clk) disable iff (srst)
    (host_en && !host_toggle && !token_start && token_done) |=> !busy_r)
    else $error("token busy not cleared");
  chk_host_follow: assert property (@(posedge clk) disable iff (srst)
    host_mode == $past(host_en))
    else $error("host mode does not follow its bit");
  chk_host_release: assert property (@(posedge clk) disable iff (srst)
    (host_rst_cnt_r == 2'h0 && !host_toggle) |=> !host_logic_reset)
    else $error("host logic reset stuck");
  chk_bus_reset_off: assert property (@(posedge clk) disable iff (srst)
    !ctrl_r[UOC_BIT_BUS_RESET] |=> !bus_reset_drive)
    else $error("bus reset not ended");
  chk_resume_follow: assert property (@(posedge clk) disable iff (srst)
    resume_drive == $past(ctrl_r[UOC_BIT_RESUME]))
    else $error("resume drive does not follow its bit");
  chk_eop_hold: assert property (@(posedge clk) disable iff (srst)
    $rose(resume_ls_eop) |-> resume_ls_eop [*8])
    else $error("low-speed eop cut short");
  chk_eop_device: assert property (@(posedge clk) disable iff (srst)
    (rs_r == UOC_RS_DRIVE && !ctrl_r[UOC_BIT_RESUME] && !host_en) |=> rs_r == UOC_RS_IDLE)
    else $error("eop appended in device mode");
  chk_pingpong: assert property (@(posedge clk) disable iff (srst)
    pingpong_pointer_clear == $past(ctrl_r[UOC_BIT_PP_CLEAR]))
    else $error("ping-pong clear does not follow its bit");
  chk_module_on: assert property (@(posedge clk) disable iff (srst)
    (!host_en && ctrl_r[UOC_BIT_EN_SOF]) |=> module_enable)
    else $error("module not enabled");
  chk_module_host: assert property (@(posedge clk) disable iff (srst)
    host_mode |-> !module_enable)
    else $error("module enable active in host mode");
  chk_hold_host: assert property (@(posedge clk) disable iff (srst)
    host_en |=> !hold_r)
    else $error("hold kept in host mode");
  chk_sof_single: assert property (@(posedge clk) disable iff (srst)
    sof_send |=> !sof_send)
    else $error("frame start longer than one cycle");
  chk_sof_off: assert property (@(posedge clk) disable iff (srst)
    (!host_en || !ctrl_r[UOC_BIT_EN_SOF]) |=> !frame_tick)
    else $error("frame timer runs while disabled");

  // Main scenarios worth seeing in a run.
  cov_setup: cover property (@(posedge clk) disable iff (srst) setup_token_rx && !host_en);
  cov_eop: cover property (@(posedge clk) disable iff (srst) resume_ls_eop);
  cov_sof: cover property (@(posedge clk) disable iff (srst) sof_send);
  cov_toggle: cover property (@(posedge clk) disable iff (srst) host_toggle);
  cov_bus_reset: cover property (@(posedge clk) disable iff (srst) bus_reset_drive);
endmodule
`default_nettype wire

// ==== uoc_link_model.sv ====
// Model of the line receiver and protocol engine that feed the control block.
`timescale 1ns/1ps
`default_nettype none
module uoc_link_model (
  // Clock
  input wire logic clk,
  // Line levels
  output logic line_j_state,
  output logic line_se0,
  // Engine events
  output logic setup_token_rx,
  output logic sof_token_rx,
  output logic [10:0] sof_frame_number,
  output logic token_start,
  output logic token_done
);
  initial begin
    {line_j_state, line_se0} = 2'h0;
    {setup_token_rx, sof_token_rx, token_start, token_done} = 4'h0;
    sof_frame_number = 11'h7FF;
  end
  task automatic set_line(input logic j, input logic se0);
    @(posedge clk);
    line_j_state <= j;
    line_se0 <= se0;
  endtask
  // One-cycle event; the frame number is scrambled once its strobe has gone.
  task automatic ev(input logic [3:0] which, input logic [10:0] fn);
    @(posedge clk);
    {setup_token_rx, sof_token_rx, token_start, token_done} <= which;
    sof_frame_number <= fn;
    @(posedge clk);
    {setup_token_rx, sof_token_rx, token_start, token_done} <= 4'h0;
    sof_frame_number <= ~fn;
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking testbench for the USB control and address registers.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uoc_pkg::*;
  localparam int FRAME = 50;
  logic clk, srst, reg_wr, reg_rd, me, hm, hlr, brd, rsd, eop, ppc, pph, sof, lsn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [6:0] dev;
  wire logic j, se0, stp, sofr, tst, tdn;
  wire logic [10:0] fn;
  int fail_count = 0;
  int tests_run = 0;
  uoc_link_model uoc_link_model_inst (.clk(clk), .line_j_state(j), .line_se0(se0),
    .setup_token_rx(stp), .sof_token_rx(sofr), .sof_frame_number(fn),
    .token_start(tst), .token_done(tdn));
  uoc_control #(.FRAME_CYCLES(FRAME)) uoc_control_inst (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_j_state(j), .line_se0(se0), .setup_token_rx(stp),
    .sof_token_rx(sofr), .sof_frame_number(fn), .token_start(tst), .token_done(tdn),
    .module_enable(me), .host_mode(hm), .host_logic_reset(hlr), .bus_reset_drive(brd),
    .resume_drive(rsd), .resume_ls_eop(eop), .pingpong_pointer_clear(ppc),
    .packet_processing_hold(pph), .sof_send(sof), .low_speed_next_token(lsn),
    .device_address_field(dev));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
    cyc(3);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Counts how long host control logic is held in reset after a mode change.
  task automatic host_rst_len(input logic [31:0] ctl);
    int n;
    n = 0;
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= UOC_OFF_CONTROL;
    reg_wdata <= ctl;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (10) begin
      @(posedge clk);
      #1 n += int'(hlr);
    end
    chk("host_logic_reset", 32'h3, n);
  endtask
  task automatic t_regs;
    rd(UOC_OFF_CONTROL);
    chk("control", 32'h0, d & 32'hFFFF_FF3F);
    rd(UOC_OFF_ADDRESS);
    chk("address", 32'h0, d);
    rd(UOC_OFF_FRAME_HIGH);
    chk("frame_high", 32'h0, d);
    wr(UOC_OFF_ADDRESS, 32'hFFFF_FF85);
    rd(UOC_OFF_ADDRESS);
    chk("address", 32'h85, d);
    chk("device_address_field", 32'h05, dev);
    chk("low_speed_next_token", 32'h1, lsn);
    wr(UOC_OFF_ADDRESS, 32'h0000_007A);
    chk("device_address_field", 32'h7A, dev);
    chk("low_speed_next_token", 32'h0, lsn);
    uoc_link_model_inst.ev(4'h4, 11'h5A7);
    wr(UOC_OFF_FRAME_LOW, 32'h0000_0011);
    rd(UOC_OFF_FRAME_LOW);
    chk("frame_low", 32'hA7, d);
    rd(UOC_OFF_FRAME_HIGH);
    chk("frame_high", 32'h5, d);
    uoc_link_model_inst.set_line(1'b1, 1'b0);
    rd(UOC_OFF_CONTROL);
    chk("line_flags", 32'h2, d[7:6]);
    uoc_link_model_inst.set_line(1'b0, 1'b1);
    rd(UOC_OFF_CONTROL);
    chk("line_flags", 32'h1, d[7:6]);
  endtask
  task automatic t_device;
    wr(UOC_OFF_CONTROL, 32'h03);
    chk("module_enable", 32'h1, me);
    chk("pingpong_pointer_clear", 32'h1, ppc);
    uoc_link_model_inst.ev(4'h8, 11'h000);
    cyc(2);
    chk("packet_processing_hold", 32'h1, pph);
    rd(UOC_OFF_CONTROL);
    chk("control_bit5", 32'h1, d[5]);
    wr(UOC_OFF_CONTROL, 32'h00);
    chk("packet_processing_hold", 32'h0, pph);
    chk("module_enable", 32'h0, me);
    chk("pingpong_pointer_clear", 32'h0, ppc);
  endtask
  task automatic t_host;
    int n;
    host_rst_len(32'h08);
    chk("host_mode", 32'h1, hm);
    rd(UOC_OFF_CONTROL);
    chk("token_in_progress", 32'h0, d[5]);
    uoc_link_model_inst.ev(4'h2, 11'h000);
    rd(UOC_OFF_CONTROL);
    chk("token_in_progress", 32'h1, d[5]);
    uoc_link_model_inst.ev(4'h1, 11'h000);
    rd(UOC_OFF_CONTROL);
    chk("token_in_progress", 32'h0, d[5]);
    wr(UOC_OFF_CONTROL, 32'h18);
    chk("bus_reset_drive", 32'h1, brd);
    wr(UOC_OFF_CONTROL, 32'h0C);
    chk("bus_reset_drive", 32'h0, brd);
    chk("resume_drive", 32'h1, rsd);
    cyc(20);
    wr(UOC_OFF_CONTROL, 32'h08);
    chk("resume_drive", 32'h0, rsd);
    chk("resume_ls_eop", 32'h1, eop);
    cyc(UOC_LS_EOP_CYCLES + 10);
    chk("resume_ls_eop", 32'h0, eop);
    wr(UOC_OFF_CONTROL, 32'h09);
    chk("module_enable", 32'h0, me);
    for (n = 0; n < 200 && sof !== 1'b1; n++) cyc(1);
    for (n = 1; n < 200; n++) begin
      cyc(1);
      if (sof === 1'b1) break;
    end
    chk("frame_period", FRAME, n);
    host_rst_len(32'h01);
    chk("host_mode", 32'h0, hm);
    wr(UOC_OFF_CONTROL, 32'h08);
    n = 0;
    repeat (3 * FRAME) begin
      cyc(1);
      n += int'(sof);
    end
    chk("sof_disabled", 32'h0, n);
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #(8 * 20000);
    fail_count++;
    results();
  end
  initial begin
    srst = 1'b1;
    {reg_wr, reg_rd} = 2'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_device();
    t_host();
    results();
  end
endmodule
`default_nettype wire
